// ### core/ppm_map.svh
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
// register offsets
`define PPM_REG_INT 8'h00
`define PPM_REG_MASK 8'h01
`define PPM_REG_DISC_POWER_OVERLOAD_CUTOFF 8'h06
`define PPM_REG_CURRENT_LIMIT_START 8'h08
`define PPM_REG_POLICE 8'h10
`define PPM_REG_CTRL 8'h11
`define PPM_REG_STATUS 8'h12
// field positions
`define PPM_INT_START_BIT 6
`define PPM_INT_PI_BIT 5
`define PPM_INT_DISC_BIT 2
`define PPM_HI_FLAG_BIT 4
`define PPM_LO_FLAG_BIT 0
`define PPM_CTRL_ON_BIT 0
`define PPM_CTRL_OFF_BIT 1
`define PPM_CTRL_FULL_BIT 2
// reset values
`define PPM_MASK_RST 8'h00
`define PPM_FULL_RST 1'b1
// police power per class, 0.5 W per lsb
`define PPM_POL_C0 8'h1F
`define PPM_POL_C1 8'h08
`define PPM_POL_C2 8'h0E
`define PPM_POL_C3 8'h1F
`define PPM_POL_C4 8'h3C
// 0.5 W lsb over 0.25 mW product lsb, raised by 15 percent
`define PPM_POL_SCALE 12'h8FC
// limits: current lsb 1 mA, voltage lsb 0.25 V
`define PPM_INRUSH_MA 10'h1A9
`define PPM_FOLD_V 8'h78
`define PPM_CURRENT_LIMIT_LOW 10'h1C2
`define PPM_CURRENT_LIMIT_C4 10'h2BC
`define PPM_DRAIN_KNEE 8'h28
// timing
`define PPM_CLK_MHZ 100
`define PPM_T_INRUSH_US 60000
`define PPM_T_MPDO_US 300000
`define PPM_INRUSH_CYC (`PPM_T_INRUSH_US * `PPM_CLK_MHZ)
`define PPM_MPDO_CYC (`PPM_T_MPDO_US * `PPM_CLK_MHZ)
`define PPM_SEV_THR 12'h400
`define PPM_SEV_UP 12'h010
`define PPM_SEV_MAX 12'hFFF
`endif

// ### core/ppm_pkg.sv
package ppm_pkg;
  typedef enum logic [1:0] {
    PPM_OFF = 2'b00,
    PPM_INRUSH = 2'b01,
    PPM_PGOOD = 2'b10
  } ppm_state_t;
  typedef logic [2:0] ppm_class_t;
endpackage : ppm_pkg

// ### core/ppm_pwr_if.sv
`timescale 1ns/10ps
interface ppm_pwr_if;
  logic sample;
  logic [7:0] volt;
  logic [9:0] curr;
  logic [7:0] police;
  logic over;
  logic over_vld;
  modport core (output sample, output volt, output curr, output police,
                input over, input over_vld);
  modport calc (input sample, input volt, input curr, input police,
                output over, output over_vld);
endinterface : ppm_pwr_if

// ### core/ppm_police.sv
`timescale 1ns/10ps
`include "ppm_map.svh"
module ppm_police (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  ppm_pwr_if.calc pwr
);
  logic [17:0] prod;
  logic [19:0] cut_lim;
  logic over_ff;
  logic vld_ff;

  assign prod = pwr.volt * pwr.curr;
  // police read live, so a host rewrite applies without a restart
  assign cut_lim = pwr.police * `PPM_POL_SCALE;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      over_ff <= 1'b0;
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= pwr.sample;
      if (pwr.sample) begin
        over_ff <= {2'h0, prod} > cut_lim;
      end
    end
  end

  assign pwr.over = over_ff;
  assign pwr.over_vld = vld_ff;
endmodule : ppm_police

// ### core/ppm_top.sv
// Summary of operation
// - switching the port on starts a fixed inrush window.
// - inrush applies 425 mA limit with 30 V foldback.
// - still limited at inrush end: port off, inrush fault event raised.
// - not limited at inrush end: enter power good, begin monitoring.
// - power good watches disconnect, current limit and overload cutoff together.
// - missing load signature for dropout time powers off, sets disconnect flag.
// - current limit template chosen by granted class, highest at low drain.
// - overcurrent lasting the limit time is a fault that removes power.
// - severity counter plus one per overcurrent sample, minus one sixteenth otherwise.
// - current above twice the limit turns the switch off at once.
// - current limit faults appear in the combined overcurrent and inrush register.
// - cutoff threshold is police power plus 15 percent.
// - in power good, power above cutoff disconnects and raises overload event.
// - default police power 4, 7, 15.5 or 30 W by class.
// - classes 0 to 3 keep below 1.05, remove above 1.25 of police.
// - class 4 keeps below 1.10, removes above 1.20 of police.
// - class done without a police write in the same cycle derives granted class, loads its police power.
// - host may rewrite police in power good; applied without restart.
// - overload cutoff faults reported beside disconnect in the combined disconnect and overload register.
// - event flags are clear-on-read, held until read.
// - event groups map to summary bits; masked ones drive active-low interrupt.
`timescale 1ns/10ps
`include "ppm_map.svh"
module ppm_top import ppm_pkg::*; #(
  parameter logic [31:0] INRUSH_CYC = `PPM_INRUSH_CYC,
  parameter logic [31:0] MPDO_CYC = `PPM_MPDO_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic cls_done_in,
  input wire logic [2:0] asked_class_in,
  input wire logic sample_in,
  input wire logic [7:0] port_volt_in,
  input wire logic [9:0] port_curr_in,
  input wire logic [7:0] drain_voltage_sense_in,
  input wire logic mps_ok_in,
  output logic fet_on_out,
  output logic inrush_foldback_out,
  output logic [7:0] fold_volt_out,
  output logic [9:0] current_limit_out,
  output logic [2:0] granted_class_out,
  output logic irq_out_n,
  output logic irq_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // limit highest at low drain, halved past the knee
  function automatic logic [9:0] current_limit_for(input ppm_class_t cls,
                                          input logic [7:0] drain);
    logic [9:0] base;
    base = (cls == 3'h4) ? `PPM_CURRENT_LIMIT_C4 : `PPM_CURRENT_LIMIT_LOW;
    if (drain > `PPM_DRAIN_KNEE) begin
      current_limit_for = {1'b0, base[9:1]};
    end else begin
      current_limit_for = base;
    end
  endfunction : current_limit_for

  function automatic logic [7:0] police_for(input ppm_class_t cls);
    case (cls)
      3'h1: police_for = `PPM_POL_C1;
      3'h2: police_for = `PPM_POL_C2;
      3'h3: police_for = `PPM_POL_C3;
      3'h4: police_for = `PPM_POL_C4;
      default: police_for = `PPM_POL_C0;
    endcase
  endfunction : police_for

  ////////////////////////////////////////////////////////////////////////////
  ppm_state_t state_ff;
  ppm_state_t nxt_state;
  logic [31:0] tmr_ff;
  logic [31:0] mpdo_ff;
  logic limited_ff;
  logic [11:0] sev_ff;
  logic [7:0] police_ff;
  logic [7:0] mask_ff;
  logic full_ff;
  ppm_class_t granted_ff;
  logic start_flag_ff;
  logic current_limit_flag_ff;
  logic gone_flag_ff;
  logic power_overload_cutoff_flag_ff;
  logic [2:0] mps_sync_ff;
  logic mps_lvl_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic [9:0] lim_ff;
  logic fold_ff;
  logic fet_ff;
  logic [7:0] fvolt_ff;
  logic wr_on;
  logic wr_off;
  logic rd_fault;
  logic rd_disc;
  logic [9:0] act_lim;
  logic inrush_done;
  logic start_ev;
  logic short_ev;
  logic current_limit_ev;
  logic power_overload_cutoff_ev;
  logic gone_ev;
  logic oc_sample;
  logic [7:0] summary;

  ppm_pwr_if pwr ();

  ppm_police u_police (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pwr(pwr)
  );

  assign pwr.sample = sample_in & (state_ff == PPM_PGOOD);
  assign pwr.volt = port_volt_in;
  assign pwr.curr = port_curr_in;
  assign pwr.police = police_ff;

  ////////////////////////////////////////////////////////////////////////////
  // load signature comparator is asynchronous to the clock
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mps_sync_ff <= 3'h0;
      mps_lvl_ff <= 1'b1;
    end else begin
      mps_sync_ff <= {mps_sync_ff[1:0], mps_ok_in};
      if (mps_sync_ff[1] == mps_sync_ff[2]) begin
        mps_lvl_ff <= mps_sync_ff[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign wr_on = reg_wr_in & hit(reg_addr_in, `PPM_REG_CTRL)
                 & reg_wdata_in[`PPM_CTRL_ON_BIT];
  assign wr_off = reg_wr_in & hit(reg_addr_in, `PPM_REG_CTRL)
                  & reg_wdata_in[`PPM_CTRL_OFF_BIT];
  assign rd_fault = reg_rd_in & hit(reg_addr_in, `PPM_REG_CURRENT_LIMIT_START);
  assign rd_disc = reg_rd_in & hit(reg_addr_in, `PPM_REG_DISC_POWER_OVERLOAD_CUTOFF);

  assign act_lim = (state_ff == PPM_INRUSH) ? `PPM_INRUSH_MA
                   : current_limit_for(granted_ff, drain_voltage_sense_in);
  assign inrush_done = (state_ff == PPM_INRUSH) && (tmr_ff == INRUSH_CYC - 32'h1);
  assign start_ev = inrush_done && limited_ff;
  assign short_ev = (state_ff != PPM_OFF) && sample_in
                    && ({1'b0, port_curr_in} > {act_lim, 1'b0});
  assign oc_sample = port_curr_in > act_lim;
  assign current_limit_ev = (state_ff == PPM_PGOOD) && (sev_ff >= `PPM_SEV_THR);
  assign power_overload_cutoff_ev = (state_ff == PPM_PGOOD) && pwr.over_vld && pwr.over;
  assign gone_ev = (state_ff == PPM_PGOOD) && !mps_lvl_ff
                   && (mpdo_ff == MPDO_CYC - 32'h1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PPM_OFF: begin
        if (wr_on && !wr_off) begin
          nxt_state = PPM_INRUSH;
        end
      end
      PPM_INRUSH: begin
        if (wr_off || short_ev || start_ev) begin
          nxt_state = PPM_OFF;
        end else if (inrush_done) begin
          nxt_state = PPM_PGOOD;
        end
      end
      PPM_PGOOD: begin
        // all three monitors run side by side
        if (wr_off || short_ev || current_limit_ev || power_overload_cutoff_ev || gone_ev) begin
          nxt_state = PPM_OFF;
        end
      end
      default: nxt_state = PPM_OFF;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_ff <= PPM_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tmr_ff <= 32'h0;
      limited_ff <= 1'b0;
    end else if (state_ff != PPM_INRUSH) begin
      tmr_ff <= 32'h0;
      limited_ff <= 1'b0;
    end else begin
      tmr_ff <= tmr_ff + 32'h1;
      if (sample_in) begin
        limited_ff <= port_curr_in >= `PPM_INRUSH_MA;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mpdo_ff <= 32'h0;
    end else if ((state_ff != PPM_PGOOD) || mps_lvl_ff) begin
      mpdo_ff <= 32'h0;
    end else if (mpdo_ff != MPDO_CYC - 32'h1) begin
      mpdo_ff <= mpdo_ff + 32'h1;
    end
  end

  // severity kept in sixteenths so the slow decay stays exact
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sev_ff <= 12'h0;
    end else if (state_ff != PPM_PGOOD) begin
      sev_ff <= 12'h0;
    end else if (sample_in) begin
      if (oc_sample) begin
        if (sev_ff > `PPM_SEV_MAX - `PPM_SEV_UP) begin
          sev_ff <= `PPM_SEV_MAX;
        end else begin
          sev_ff <= sev_ff + `PPM_SEV_UP;
        end
      end else if (sev_ff != 12'h0) begin
        sev_ff <= sev_ff - 12'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      granted_ff <= 3'h0;
      police_ff <= `PPM_POL_C0;
    end else if (reg_wr_in && hit(reg_addr_in, `PPM_REG_POLICE)) begin
      police_ff <= reg_wdata_in;
    end else if (cls_done_in) begin
      // demotion only ever goes from class 4 down to class 3
      if (asked_class_in == 3'h4 && !full_ff) begin
        granted_ff <= 3'h3;
        police_ff <= police_for(3'h3);
      end else begin
        granted_ff <= asked_class_in;
        police_ff <= police_for(asked_class_in);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mask_ff <= `PPM_MASK_RST;
      full_ff <= `PPM_FULL_RST;
    end else if (reg_wr_in) begin
      if (hit(reg_addr_in, `PPM_REG_MASK)) begin
        mask_ff <= reg_wdata_in;
      end
      if (hit(reg_addr_in, `PPM_REG_CTRL)) begin
        full_ff <= reg_wdata_in[`PPM_CTRL_FULL_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a new event in the read cycle survives the clear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      start_flag_ff <= 1'b0;
      current_limit_flag_ff <= 1'b0;
      gone_flag_ff <= 1'b0;
      power_overload_cutoff_flag_ff <= 1'b0;
    end else begin
      start_flag_ff <= (start_flag_ff & ~rd_fault) | start_ev;
      current_limit_flag_ff <= (current_limit_flag_ff & ~rd_fault) | current_limit_ev | short_ev;
      gone_flag_ff <= (gone_flag_ff & ~rd_disc) | gone_ev;
      power_overload_cutoff_flag_ff <= (power_overload_cutoff_flag_ff & ~rd_disc) | power_overload_cutoff_ev;
    end
  end

  always_comb begin
    summary = 8'h00;
    summary[`PPM_INT_START_BIT] = start_flag_ff;
    summary[`PPM_INT_PI_BIT] = current_limit_flag_ff;
    summary[`PPM_INT_DISC_BIT] = gone_flag_ff | power_overload_cutoff_flag_ff;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(summary & mask_ff);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_ff <= 8'h00;
      if (hit(reg_addr_in, `PPM_REG_INT)) begin
        rdata_ff <= summary;
      end else if (hit(reg_addr_in, `PPM_REG_MASK)) begin
        rdata_ff <= mask_ff;
      end else if (rd_disc) begin
        rdata_ff[`PPM_HI_FLAG_BIT] <= gone_flag_ff;
        rdata_ff[`PPM_LO_FLAG_BIT] <= power_overload_cutoff_flag_ff;
      end else if (rd_fault) begin
        rdata_ff[`PPM_HI_FLAG_BIT] <= current_limit_flag_ff;
        rdata_ff[`PPM_LO_FLAG_BIT] <= start_flag_ff;
      end else if (hit(reg_addr_in, `PPM_REG_POLICE)) begin
        rdata_ff <= police_ff;
      end else if (hit(reg_addr_in, `PPM_REG_CTRL)) begin
        rdata_ff[`PPM_CTRL_FULL_BIT] <= full_ff;
      end else if (hit(reg_addr_in, `PPM_REG_STATUS)) begin
        rdata_ff <= {2'h0, nxt_state != PPM_OFF, granted_ff, state_ff};
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fold_ff <= 1'b0;
      fet_ff <= 1'b0;
      fvolt_ff <= 8'h00;
      lim_ff <= 10'h0;
    end else begin
      // taken from next state so pins come off flops with no extra lag
      fet_ff <= nxt_state != PPM_OFF;
      fvolt_ff <= (nxt_state == PPM_INRUSH) ? `PPM_FOLD_V : 8'h00;
      fold_ff <= nxt_state == PPM_INRUSH;
      if (nxt_state == PPM_INRUSH) begin
        lim_ff <= `PPM_INRUSH_MA;
      end else begin
        lim_ff <= current_limit_for(granted_ff, drain_voltage_sense_in);
      end
    end
  end

  assign fet_on_out = fet_ff;
  assign inrush_foldback_out = fold_ff;
  assign fold_volt_out = fvolt_ff;
  assign current_limit_out = lim_ff;
  assign granted_class_out = granted_ff;
  assign irq_out_n = 1'b0;
  assign irq_oe_out = irq_ff;
  assign reg_rdata_out = rdata_ff;
endmodule : ppm_top

// ### verification/ppm_top_props.sv
`timescale 1ns/10ps
`include "ppm_map.svh"
module ppm_top_props #(
  parameter logic [31:0] INRUSH_CYC = `PPM_INRUSH_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic sample_in,
  input wire logic [9:0] port_curr_in,
  input wire logic [7:0] drain_voltage_sense_in,
  input wire logic fet_on_out,
  input wire logic inrush_foldback_out,
  input wire logic [7:0] fold_volt_out,
  input wire logic [9:0] current_limit_out,
  input wire logic [2:0] granted_class_out,
  input wire logic irq_out_n,
  input wire logic irq_oe_out
);
  logic [31:0] fold_cnt_ff;
  logic [9:0] lim_exp;
  logic lim_seen_ff;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  // length of the current foldback run, compared on its fall
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !inrush_foldback_out) begin
      fold_cnt_ff <= 32'h0;
    end else begin
      fold_cnt_ff <= fold_cnt_ff + 32'h1;
    end
  end
  // still limited: last sample taken inside the window at or over 425 mA
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !inrush_foldback_out) begin
      lim_seen_ff <= 1'b0;
    end else if (sample_in) begin
      lim_seen_ff <= port_curr_in >= 10'h1A9;
    end
  end
  // template: wide limit for the top class, halved once the drain rises
  assign lim_exp = (granted_class_out == 3'h4 ? `PPM_CURRENT_LIMIT_C4 : `PPM_CURRENT_LIMIT_LOW)
                   >> (drain_voltage_sense_in > `PPM_DRAIN_KNEE);
  ////////////////////////////////////////////////////////////
  a_fold_volt_val: assert property (fold_volt_out == (inrush_foldback_out ? 8'h78 : 8'h00))
    else $error("foldback voltage wrong");
  a_inrush_limit_set: assert property ($rose(inrush_foldback_out) |-> current_limit_out == 10'h1A9)
    else $error("inrush limit not 425 mA");
  a_power_on_start: assert property (reg_wr_in && reg_addr_in == `PPM_REG_CTRL
    && reg_wdata_in[1:0] == 2'b01 && !fet_on_out |=> fet_on_out ##1 inrush_foldback_out)
    else $error("power on did not start inrush");
  a_inrush_length: assert property ($fell(inrush_foldback_out) && fet_on_out |-> fold_cnt_ff == INRUSH_CYC)
    else $error("inrush window length wrong");
  a_short_trip: assert property (sample_in && fet_on_out
    && {1'b0, port_curr_in} > {current_limit_out, 1'b0} |=> !fet_on_out)
    else $error("short did not turn switch off");
  a_inrush_fault: assert property (inrush_foldback_out && fold_cnt_ff == INRUSH_CYC - 32'h1
    && lim_seen_ff |=> !fet_on_out)
    else $error("limited port kept on after inrush");
  a_template_limit: assert property (fet_on_out && !inrush_foldback_out ##1 fet_on_out
    && !inrush_foldback_out && $stable(drain_voltage_sense_in) && $stable(granted_class_out)
    |-> current_limit_out == lim_exp)
    else $error("template limit wrong");
  a_irq_masked_off: assert property (reg_wr_in && reg_addr_in == `PPM_REG_MASK && reg_wdata_in == 8'h00
    ##1 !(reg_wr_in && reg_addr_in == `PPM_REG_MASK) |=> !irq_oe_out)
    else $error("masked interrupt still driven");
  a_irq_pin_low: assert property (irq_out_n == 1'b0)
    else $error("interrupt pin data not low");
endmodule : ppm_top_props

bind ppm_top ppm_top_props #(.INRUSH_CYC(INRUSH_CYC)) u_props (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .sample_in(sample_in),
  .port_curr_in(port_curr_in), .drain_voltage_sense_in(drain_voltage_sense_in),
  .fet_on_out(fet_on_out), .inrush_foldback_out(inrush_foldback_out),
  .fold_volt_out(fold_volt_out), .current_limit_out(current_limit_out),
  .granted_class_out(granted_class_out), .irq_out_n(irq_out_n), .irq_oe_out(irq_oe_out));

// ### verification/ppm_pd_model.sv
`timescale 1ns/10ps
module ppm_pd_model (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic fet_on_in,
  input wire logic [9:0] load_ma_in,
  input wire logic mps_en_in,
  output logic sample_out,
  output logic [7:0] volt_out,
  output logic [9:0] curr_out,
  output logic mps_ok_out
);
  logic [1:0] div_ff;
  // slow measurement: one sample every fourth cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  assign sample_out = div_ff == 2'h3;
  // unpowered load draws nothing and shows no signature
  assign volt_out = fet_on_in ? 8'hC8 : 8'h00;
  assign curr_out = fet_on_in ? load_ma_in : 10'h000;
  assign mps_ok_out = fet_on_in & mps_en_in;
endmodule : ppm_pd_model

// ### verification/ppm_top_tb.sv
`timescale 1ns/10ps
`include "ppm_map.svh"
module ppm_top_tb;
  localparam int INR = 50;
  localparam int MPD = 40;
  typedef struct packed {logic [2:0] cls; logic full; logic [2:0] grant; logic [7:0] pol;} ppm_row_t;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, cls_done_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, drain = 8'h10, reg_rdata_out, volt;
  logic [2:0] asked = 3'h0;
  logic [9:0] load = 10'h050, curr;
  logic mps_en = 1'b1, sample, mps_ok, fet_on_out, inrush_foldback_out, irq_out_n, irq_oe_out;
  logic [7:0] fold_volt_out;
  logic [9:0] current_limit_out;
  logic [2:0] granted_class_out;
  int n_errors = 0, n_tests = 0;
  ppm_row_t rows [6] = '{'{3'h0, 1'b1, 3'h0, 8'h1F}, '{3'h1, 1'b1, 3'h1, 8'h08},
    '{3'h2, 1'b1, 3'h2, 8'h0E}, '{3'h4, 1'b1, 3'h4, 8'h3C}, '{3'h4, 1'b0, 3'h3, 8'h1F},
    '{3'h3, 1'b1, 3'h3, 8'h1F}};
  always #5 mclk_in = ~mclk_in;
  ppm_pd_model u_pd (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .fet_on_in(fet_on_out),
    .load_ma_in(load), .mps_en_in(mps_en), .sample_out(sample), .volt_out(volt),
    .curr_out(curr), .mps_ok_out(mps_ok));
  ppm_top #(.INRUSH_CYC(32'(INR)), .MPDO_CYC(32'(MPD))) DUT (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .cls_done_in(cls_done_in), .asked_class_in(asked), .sample_in(sample),
    .port_volt_in(volt), .port_curr_in(curr), .drain_voltage_sense_in(drain),
    .mps_ok_in(mps_ok), .fet_on_out(fet_on_out), .inrush_foldback_out(inrush_foldback_out),
    .fold_volt_out(fold_volt_out), .current_limit_out(current_limit_out),
    .granted_class_out(granted_class_out), .irq_out_n(irq_out_n), .irq_oe_out(irq_oe_out));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  // strobes drop for a cycle so back-to-back calls never rewrite them in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    tick(1);
    reg_wr_in <= 1'b0;
    tick(1);
  endtask : wr_reg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    tick(1);
    reg_rd_in <= 1'b0;
    #1;
    check(16'(reg_rdata_out), 16'(e), "rdata");
    tick(1);
  endtask : rchk
  task automatic fet_is(input logic v);
    #1;
    check(16'(fet_on_out), 16'(v), "fet");
    tick(1);
  endtask : fet_is
  task automatic power_on(input logic [9:0] ma);
    load <= ma;
    wr_reg(`PPM_REG_CTRL, 8'h05);
    #1;
    check(16'(fet_on_out), 16'h1, "fet on");
    check(16'(fold_volt_out), 16'h78, "fold");
    check(16'(current_limit_out), 16'h1A9, "current_limit");
    tick(INR + 5);
  endtask : power_on
  task automatic final_report();
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    n_errors++;
    $display("BAD %0t timeout", $time);
    final_report();
  end
  initial begin
    tick(4);
    rst_n_in <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      wr_reg(`PPM_REG_CTRL, {5'h00, rows[i].full, 2'b00});
      asked <= rows[i].cls;
      cls_done_in <= 1'b1;
      tick(1);
      cls_done_in <= 1'b0;
      tick(1);
      check(16'(granted_class_out), 16'(rows[i].grant), "class");
      rchk(`PPM_REG_POLICE, rows[i].pol);
      rchk(`PPM_REG_STATUS, {3'h0, rows[i].grant, 2'h0});
    end
    // lowered police limit while powered, then a load just over it
    power_on(10'h050);
    rchk(`PPM_REG_STATUS, 8'h2E);
    wr_reg(`PPM_REG_POLICE, 8'h08);
    tick(20);
    fet_is(1'b1);
    load <= 10'h064;
    tick(12);
    fet_is(1'b0);
    wr_reg(`PPM_REG_MASK, 8'hFF);
    fet_is(1'b0);
    check(16'(irq_oe_out), 16'h1, "irq");
    wr_reg(`PPM_REG_MASK, 8'h00);
    fet_is(1'b0);
    check(16'(irq_oe_out), 16'h0, "irq");
    rchk(`PPM_REG_INT, 8'h04);
    rchk(`PPM_REG_DISC_POWER_OVERLOAD_CUTOFF, 8'h01);
    rchk(`PPM_REG_DISC_POWER_OVERLOAD_CUTOFF, 8'h00);
    wr_reg(`PPM_REG_POLICE, 8'h3C);
    // still limited when the window closes
    power_on(10'h1AE);
    fet_is(1'b0);
    rchk(`PPM_REG_INT, 8'h40);
    rchk(`PPM_REG_CURRENT_LIMIT_START, 8'h01);
    // drain rise halves the template, then a slow overload trips it
    power_on(10'h050);
    drain <= 8'h50;
    tick(8);
    #1;
    check(16'(current_limit_out), 16'h0E1, "template");
    tick(1);
    drain <= 8'h10;
    tick(4);
    load <= 10'h1CC;
    tick(200);
    fet_is(1'b1);
    tick(80);
    fet_is(1'b0);
    rchk(`PPM_REG_CURRENT_LIMIT_START, 8'h10);
    power_on(10'h050);
    load <= 10'h3E8;
    tick(6);
    fet_is(1'b0);
    rchk(`PPM_REG_CURRENT_LIMIT_START, 8'h10);
    power_on(10'h050);
    mps_en <= 1'b0;
    tick(MPD + 12);
    fet_is(1'b0);
    rchk(`PPM_REG_DISC_POWER_OVERLOAD_CUTOFF, 8'h10);
    mps_en <= 1'b1;
    // top class: kept just under 1.10 of police, cut just over 1.20
    asked <= 3'h4;
    cls_done_in <= 1'b1;
    tick(1);
    cls_done_in <= 1'b0;
    power_on(10'h050);
    load <= 10'h280;
    tick(20);
    fet_is(1'b1);
    load <= 10'h2E4;
    tick(12);
    fet_is(1'b0);
    rchk(`PPM_REG_DISC_POWER_OVERLOAD_CUTOFF, 8'h01);
    // power off in power good, then off beside on while off
    power_on(10'h050);
    wr_reg(`PPM_REG_CTRL, 8'h07);
    fet_is(1'b0);
    wr_reg(`PPM_REG_CTRL, 8'h07);
    fet_is(1'b0);
    rchk(`PPM_REG_STATUS, 8'h10);
    rst_n_in <= 1'b0;
    tick(4);
    rst_n_in <= 1'b1;
    tick(1);
    rchk(`PPM_REG_MASK, 8'h00);
    rchk(`PPM_REG_POLICE, 8'h1F);
    rchk(`PPM_REG_STATUS, 8'h00);
    rchk(8'h3F, 8'h00);
    final_report();
  end
endmodule : ppm_top_tb
